/* File: clock_synthesis_control.sv */
// control register, lock tracking and clock selection of the clock synthesizer
// Functional notes
// (R1) clock_out_select picks phase, reserved, ref, ref/2
// (R2) codec from divider or reference over 6.5
// (R3) loop reference always from input divider
// (R4) hardware reset clears codec select
// (R5) power-down bit stops the loop
// (R6) power-down refused while loop enabled
// (R7) setting power-down clears lock
// (R8) enable selects loop output for core
// (R9) enable/power-down pair decoded, 11 reserved
// (R10) software bypasses, powers down, then stops
// (R11) software bypasses before changing dividers, polls lock
// (R12) lock reads one once loop locked
// (R13) divider write clears lock, enable clear not
// (R14) lock bit is read-only
// (R15) bits 8-9 read zero
// (R16) input divider divides by value plus one
// (R17) loop multiplies by four times value plus one
// (R18) input divider at bits 0-3
// (R19) feedback divider at bits 4-7
// (R20) clock-out select at bits 10-11
// (R21) hardware reset clears whole register
// (R22) core clock switch without runt pulses
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`include "csc_regs.svh"
module clock_synthesis_control
#(
  parameter int LOCK_CYCLES = (`CSC_LOCK_US * `CSC_CLK_MHZ)
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        external_reference_pin,
  input  wire logic        core_phase_clock,
  output logic             core_ref_en,
  output logic             core_clk_from_loop,
  output logic             loop_ref_tick,
  output logic       [3:0] loop_feedback_modulus,
  output logic       [6:0] loop_multiplier,
  output logic             loop_powered_down,
  output logic             loop_mode_reserved,
  output logic             codec_clk_tick,
  output logic             clock_out_pin
);
  logic [15:0]            ctrl_q;
  logic                   lock_q;
  logic                   clkout_dis_q;
  logic [15:0]            lock_cnt_q;
  logic [1:0]             ext_sync_q;
  logic                   ext_prev_q;
  logic [1:0]             ph_sync_q;
  logic                   co_q;
  logic                   half_lvl_q;
  csc_pkg::csc_sw_state_t sw_q;
  logic                   wr;
  logic                   wr_ctrl;
  logic                   new_pd;
  logic                   div_change;
  logic                   ext_rise;
  logic [15:0]            ctrl_rd;
  csc_div_if              dif ();

  ////////////////////////////////////////////////////////////////////////////////
  // apb slave: zero-wait, unmapped addresses answer pslverr
  assign wr      = psel && penable && pwrite;
  assign wr_ctrl = wr && (paddr == `CSC_CTRL_OFFSET);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && (paddr != `CSC_CTRL_OFFSET) && (paddr != `CSC_EXT_OFFSET);

  // power-down may be set only while enable is clear in the stored value
  assign new_pd = pwdata[`CSC_PD_BIT] && !ctrl_q[`CSC_EN_BIT]; // see (R6)
  assign div_change = wr_ctrl && (pwdata[`CSC_YD_MSB:`CSC_ED_LSB] != ctrl_q[`CSC_YD_MSB:`CSC_ED_LSB]);

  // control register, cleared by hardware reset only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_q <= `CSC_CTRL_RESET; // see (R21) see (R4)
    else if (wr_ctrl)
    begin
      ctrl_q[`CSC_ED_MSB:`CSC_ED_LSB]   <= pwdata[`CSC_ED_MSB:`CSC_ED_LSB]; // see (R18)
      ctrl_q[`CSC_YD_MSB:`CSC_YD_LSB]   <= pwdata[`CSC_YD_MSB:`CSC_YD_LSB]; // see (R19)
      ctrl_q[`CSC_RSV_MSB:`CSC_RSV_LSB] <= 2'h0; // see (R15)
      ctrl_q[`CSC_CS_MSB:`CSC_CS_LSB]   <= pwdata[`CSC_CS_MSB:`CSC_CS_LSB]; // see (R20)
      ctrl_q[`CSC_GSM_BIT]              <= pwdata[`CSC_GSM_BIT];
      ctrl_q[`CSC_PD_BIT]               <= new_pd; // see (R6)
      ctrl_q[`CSC_EN_BIT]               <= pwdata[`CSC_EN_BIT];
      ctrl_q[`CSC_LOCK_BIT]             <= 1'b0; // see (R14)
    end
  end

  // clock-out disable of the operating-mode register, mirrored here
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clkout_dis_q <= 1'b0;
    else if (wr && paddr == `CSC_EXT_OFFSET)
      clkout_dis_q <= pwdata[`CSC_CLKOUT_DIS_BIT];
  end

  // read data register
  assign ctrl_rd = {lock_q, ctrl_q[14:10], 2'h0, ctrl_q[7:0]}; // see (R15) see (R12)
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
      prdata <= (paddr == `CSC_CTRL_OFFSET) ? {16'h0000, ctrl_rd} :
                (paddr == `CSC_EXT_OFFSET)  ? {31'h00000000, clkout_dis_q} : 32'h00000000;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reference pin synchroniser and edge detect
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_sync_q <= 2'h0;
      ext_prev_q <= 1'b0;
      ph_sync_q  <= 2'h0;
    end
    else
    begin
      ext_sync_q <= {ext_sync_q[0], external_reference_pin};
      ext_prev_q <= ext_sync_q[1];
      ph_sync_q  <= {ph_sync_q[0], core_phase_clock};
    end
  end
  assign ext_rise = ext_sync_q[1] && !ext_prev_q;

  assign dif.ref_en        = ext_rise;
  assign dif.input_divider = ctrl_q[`CSC_ED_MSB:`CSC_ED_LSB];
  csc_divider u_div
  (
    .pclk    (pclk),
    .presetn (presetn),
    .dif     (dif)
  );

  // loop always takes the divided reference
  assign loop_ref_tick         = dif.div_tick; // see (R3)
  assign loop_feedback_modulus = ctrl_q[`CSC_YD_MSB:`CSC_YD_LSB]; // see (R19)
  assign loop_multiplier       = {1'b0, ctrl_q[`CSC_YD_MSB:`CSC_YD_LSB], 2'h0} + 7'h04; // see (R17)
  assign loop_powered_down     = ctrl_q[`CSC_PD_BIT]; // see (R5)
  assign loop_mode_reserved    = ctrl_q[`CSC_EN_BIT] && ctrl_q[`CSC_PD_BIT]; // see (R9)
  assign core_ref_en           = ext_rise;
  // codec source select
  assign codec_clk_tick = ctrl_q[`CSC_GSM_BIT] ? dif.codec_frac_tick : dif.div_tick; // see (R2)

  ////////////////////////////////////////////////////////////////////////////////
  // lock tracking: counts pclk cycles while loop is not powered down
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lock_q     <= 1'b0;
      lock_cnt_q <= 16'h0000;
    end
    else if (ctrl_q[`CSC_PD_BIT] || div_change || (wr_ctrl && new_pd))
    begin
      lock_q     <= 1'b0; // see (R7) see (R13)
      lock_cnt_q <= 16'h0000;
    end
    else if (lock_cnt_q >= 16'(LOCK_CYCLES - 1))
      lock_q     <= 1'b1; // see (R12)
    else
      lock_cnt_q <= lock_cnt_q + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // core clock switch: hand over only at a reference edge, to the loop after a one-reference-period gap, back directly
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sw_q <= csc_pkg::CSC_SRC_EXT;
    else
    begin
      unique case (sw_q)
        csc_pkg::CSC_SRC_EXT:
          if (ctrl_q[`CSC_EN_BIT] && !ctrl_q[`CSC_PD_BIT] && ext_rise)
            sw_q <= csc_pkg::CSC_SRC_GAP; // see (R22)
        csc_pkg::CSC_SRC_GAP:
          if (ext_rise)
            sw_q <= (ctrl_q[`CSC_EN_BIT] && !ctrl_q[`CSC_PD_BIT]) ? csc_pkg::CSC_SRC_PLL : csc_pkg::CSC_SRC_EXT;
        csc_pkg::CSC_SRC_PLL:
          if (!ctrl_q[`CSC_EN_BIT] && ext_rise)
            sw_q <= csc_pkg::CSC_SRC_EXT; // see (R8)
        default:
          sw_q <= csc_pkg::CSC_SRC_EXT;
      endcase
    end
  end
  assign core_clk_from_loop = (sw_q == csc_pkg::CSC_SRC_PLL); // see (R8)

  ////////////////////////////////////////////////////////////////////////////////
  // clock-out pin mux, registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      half_lvl_q <= 1'b0;
    else
      half_lvl_q <= dif.half_tick; // see (R1)
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      co_q <= 1'b0;
    else if (clkout_dis_q)
      co_q <= 1'b0;
    else
    begin
      unique case (csc_pkg::csc_co_sel_t'(ctrl_q[`CSC_CS_MSB:`CSC_CS_LSB]))
        csc_pkg::CSC_CO_PHASE:    co_q <= ph_sync_q[1]; // see (R1)
        csc_pkg::CSC_CO_RSV:      co_q <= 1'b0;
        csc_pkg::CSC_CO_EXT:      co_q <= ext_sync_q[1];
        csc_pkg::CSC_CO_EXT_HALF: co_q <= half_lvl_q;
      endcase
    end
  end
  assign clock_out_pin = co_q;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  AST_PD_REFUSED: assert property (@(posedge pclk) disable iff (!presetn) // see (R6)
    (wr_ctrl && ctrl_q[`CSC_EN_BIT]) |=> !ctrl_q[`CSC_PD_BIT])
    else $error("power-down set while loop enabled");
  AST_PD_CLEARS_LOCK: assert property (@(posedge pclk) disable iff (!presetn) // see (R7)
    $rose(ctrl_q[`CSC_PD_BIT]) |=> !lock_q)
    else $error("lock survived power-down");
  AST_DIV_CLEARS_LOCK: assert property (@(posedge pclk) disable iff (!presetn) // see (R13)
    div_change |=> !lock_q)
    else $error("lock survived divider change");
  AST_RSV_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // see (R15)
    ctrl_rd[`CSC_RSV_MSB:`CSC_RSV_LSB] == 2'h0)
    else $error("reserved bits nonzero");
  AST_LOCK_RO: assert property (@(posedge pclk) disable iff (!presetn) // see (R14)
    (wr_ctrl && !div_change && !lock_q && !new_pd) |=> (lock_q == $past(lock_cnt_q >= 16'(LOCK_CYCLES - 1))))
    else $error("lock written by software");
  AST_PLL_NEEDS_EN: assert property (@(posedge pclk) disable iff (!presetn) // see (R8)
    $rose(core_clk_from_loop) |-> $past(ctrl_q[`CSC_EN_BIT]))
    else $error("core on loop without enable");
  AST_CODEC_SRC: assert property (@(posedge pclk) disable iff (!presetn) // see (R2)
    (!ctrl_q[`CSC_GSM_BIT] |-> codec_clk_tick == dif.div_tick))
    else $error("codec source wrong");
  AST_MULT: assert property (@(posedge pclk) disable iff (!presetn) // see (R17)
    loop_multiplier == 7'(4 * (ctrl_q[`CSC_YD_MSB:`CSC_YD_LSB] + 1)))
    else $error("multiplier wrong");
  AST_CO_OFF: assert property (@(posedge pclk) disable iff (!presetn) // see (R1)
    clkout_dis_q |=> !clock_out_pin)
    else $error("clock-out not disabled");
  COV_LOCK: cover property (@(posedge pclk) disable iff (!presetn) $rose(lock_q));
  COV_TO_PLL: cover property (@(posedge pclk) disable iff (!presetn) $rose(core_clk_from_loop));
  COV_PD: cover property (@(posedge pclk) disable iff (!presetn) $rose(ctrl_q[`CSC_PD_BIT]));
endmodule

/* File: clock_synthesis_control_tb.sv */
// self-checking testbench of the clock synthesis control block
`timescale 1ns/10ps
`include "csc_regs.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module clock_synthesis_control_tb;
  logic        pclk, presetn, psel, penable, pwrite, external_reference_pin, core_phase_clock;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat, w;
  logic        pready, pslverr, rerr, core_ref_en, core_clk_from_loop, loop_ref_tick;
  logic [3:0]  loop_feedback_modulus;
  logic [6:0]  loop_multiplier;
  logic        loop_powered_down, loop_mode_reserved, codec_clk_tick, clock_out_pin;
  logic [15:0] shadow;
  logic [2:0]  ph_cnt;
  logic [1:0]  ref_cnt;
  int          n_mismatch, checks, seed, cyc, nr, nl, nc, no;
  clock_synthesis_control #(.LOCK_CYCLES(8)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_reference_pin(external_reference_pin), .core_phase_clock(core_phase_clock),
    .core_ref_en(core_ref_en), .core_clk_from_loop(core_clk_from_loop), .loop_ref_tick(loop_ref_tick),
    .loop_feedback_modulus(loop_feedback_modulus), .loop_multiplier(loop_multiplier),
    .loop_powered_down(loop_powered_down), .loop_mode_reserved(loop_mode_reserved),
    .codec_clk_tick(codec_clk_tick), .clock_out_pin(clock_out_pin));
  ////////////////////////////////////////////////////////////////////////////
  // clock, reference with a four-cycle period, phase clock with a six-cycle period
  always #20 pclk = ~pclk;
  always @(posedge pclk)
  begin
    ref_cnt <= ref_cnt + 2'h1;
    external_reference_pin <= ref_cnt[1];
    ph_cnt <= (ph_cnt == 3'h5) ? 3'h0 : ph_cnt + 3'h1;
    core_phase_clock <= (ph_cnt < 3'h3);
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // stored value after a write: reserved and status bits drop, power-down refused while enabled
  function automatic logic [15:0] exp_ctrl(input logic [15:0] old, input logic [31:0] wd);
    logic [15:0] r;
    r = wd[15:0] & 16'h7CFF;
    r[13] = wd[13] & ~old[14];
    return r;
  endfunction
  function automatic logic in_rng(input int v, input int e, input int t);
    return (v >= e - t) && (v <= e + t);
  endfunction
  // one APB transfer, held until pready is seen high
  task automatic apb(input logic [11:0] a, input logic wr, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wait_lock();
    int i;
    for (i = 0; i < 100; i++)
    begin
      apb(`CSC_CTRL_OFFSET, 1'b0, 32'h0);
      if (rdat[15] === 1'b1) break;
    end
  endtask
  task automatic wait_sw(input logic v);
    int i;
    for (i = 0; i < 60 && core_clk_from_loop !== v; i++) @(posedge pclk);
  endtask
  // count output pulses and clock-out rises over a window
  task automatic count_win(input int n);
    logic p;
    nr = 0; nl = 0; nc = 0; no = 0;
    repeat (8) @(posedge pclk);
    p = clock_out_pin;
    repeat (n)
    begin
      @(posedge pclk);
      nr += (core_ref_en === 1'b1);
      nl += (loop_ref_tick === 1'b1);
      nc += (codec_clk_tick === 1'b1);
      no += (clock_out_pin === 1'b1 && p !== 1'b1);
      p = clock_out_pin;
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    seed = 32'h37d6471a;
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    external_reference_pin = 0; core_phase_clock = 0; ph_cnt = 0; ref_cnt = 0; cyc = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(`CSC_CTRL_OFFSET, 1'b0, 32'h0);
    `CHK("ctrl reset", 32'h0, rdat)
    $display("test reset done");
    shadow = 16'h0;
    repeat (24)
    begin
      w = $random(seed);
      if (w[14]) w[13] = 1'b0;
      apb(`CSC_CTRL_OFFSET, 1'b1, w);
      shadow = exp_ctrl(shadow, w);
      apb(`CSC_CTRL_OFFSET, 1'b0, 32'h0);
      `CHK("ctrl readback", {16'h0, shadow}, rdat & 32'hFFFF7FFF)
      `CHK("modulus", shadow[7:4], loop_feedback_modulus)
      `CHK("multiplier", 7'(4 * (shadow[7:4] + 1)), loop_multiplier)
      `CHK("powered down", shadow[13], loop_powered_down)
      `CHK("mode reserved", 1'b0, loop_mode_reserved)
    end
    $display("test random writes done");
    // bypassed loop: new dividers, poll lock, then enable
    apb(`CSC_CTRL_OFFSET, 1'b1, 32'h32);
    wait_lock();
    `CHK("lock set", 1'b1, rdat[15])
    apb(`CSC_CTRL_OFFSET, 1'b1, 32'h4032);
    wait_sw(1'b1);
    `CHK("core from loop", 1'b1, core_clk_from_loop)
    apb(`CSC_CTRL_OFFSET, 1'b1, 32'h6032);
    apb(`CSC_CTRL_OFFSET, 1'b0, 32'h0);
    `CHK("pd refused", 32'hC032, rdat)
    // power-down order: bypass first, then power down
    apb(`CSC_CTRL_OFFSET, 1'b1, 32'h0032);
    apb(`CSC_CTRL_OFFSET, 1'b0, 32'h0);
    `CHK("lock kept", 32'h8032, rdat)
    wait_sw(1'b0);
    `CHK("core from ref", 1'b0, core_clk_from_loop)
    apb(`CSC_CTRL_OFFSET, 1'b1, 32'h2032);
    repeat (40) @(posedge pclk);
    apb(`CSC_CTRL_OFFSET, 1'b0, 32'h0);
    `CHK("pd clears lock", 32'h2032, rdat)
    apb(`CSC_CTRL_OFFSET, 1'b1, 32'h32);
    wait_lock();
    apb(`CSC_CTRL_OFFSET, 1'b1, 32'h33);
    apb(`CSC_CTRL_OFFSET, 1'b0, 32'h0);
    `CHK("input div clears lock", 32'h33, rdat)
    wait_lock();
    apb(`CSC_CTRL_OFFSET, 1'b1, 32'h43);
    apb(`CSC_CTRL_OFFSET, 1'b0, 32'h0);
    `CHK("feedback div clears lock", 32'h43, rdat)
    $display("test lock done");
    foreach (shadow[i])
    begin
      if (i > 5) continue;
      w = {19'h0, i[0], 8'h0, (i < 2) ? 4'h0 : (i < 4) ? 4'h2 : 4'hF};
      apb(`CSC_CTRL_OFFSET, 1'b1, w);
      count_win(208);
      `CHK("ref pulses", 1'b1, in_rng(nr, 52, 1))
      `CHK("loop ref ticks", 1'b1, in_rng(nl, 52 / (w[3:0] + 1), 1))
      `CHK("codec ticks", 1'b1, in_rng(nc, w[12] ? 8 : 52 / (w[3:0] + 1), 1))
    end
    $display("test dividers done");
    apb(`CSC_EXT_OFFSET, 1'b1, 32'h0);
    for (int cs = 0; cs < 4; cs++)
    begin
      apb(`CSC_CTRL_OFFSET, 1'b1, cs << 10);
      count_win(240);
      if (cs != 1) `CHK("clock out rises", 1'b1, in_rng(no, (cs == 0) ? 40 : (cs == 2) ? 60 : 30, 2))
    end
    apb(`CSC_EXT_OFFSET, 1'b1, 32'h1);
    count_win(240);
    `CHK("clock out disabled", 0, no)
    $display("test clock out done");
    apb(12'h008, 1'b1, 32'hFFFF);
    `CHK("unmapped write err", 1'b1, rerr)
    apb(12'h008, 1'b0, 32'h0);
    `CHK("unmapped read", 33'h100000000, {rerr, rdat})
    apb(`CSC_CTRL_OFFSET, 1'b0, 32'h0);
    `CHK("ctrl untouched", 32'hC00, rdat & 32'hFFFF7FFF)
    $display("test unmapped done");
    close_out();
  end
endmodule

/* File: csc_div_if.sv */
// bundle between the control top and the divider module
`timescale 1ns/10ps
interface csc_div_if;
  logic       ref_en;
  logic [3:0] input_divider;
  logic       div_tick;
  logic       half_tick;
  logic       codec_frac_tick;
  modport ctrl (output ref_en, output input_divider, input div_tick, input half_tick, input codec_frac_tick);
  modport div  (input ref_en, input input_divider, output div_tick, output half_tick, output codec_frac_tick);
endinterface

/* File: csc_divider.sv */
// reference dividers: programmable by n+1, fixed by two and fixed by 6.5
`timescale 1ns/10ps
module csc_divider
(
  input  wire logic  pclk,
  input  wire logic  presetn,
  csc_div_if.div     dif
);
  logic [3:0] cnt_q;
  logic       half_q;
  logic [3:0] frac_q;

  // divide by input_divider plus one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= 4'h0;
    else if (dif.ref_en)
    begin
      if (cnt_q >= dif.input_divider)
        cnt_q <= 4'h0;
      else
        cnt_q <= cnt_q + 4'h1;
    end
  end
  assign dif.div_tick = dif.ref_en && (cnt_q >= dif.input_divider); // see (R16)

  // halved reference: a level that flips on every reference rise
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      half_q <= 1'b0;
    else if (dif.ref_en)
      half_q <= ~half_q;
  end
  assign dif.half_tick = half_q; // see (R1)

  // 6.5 divide: two ticks in 13 reference edges
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      frac_q <= 4'h0;
    else if (dif.ref_en)
      frac_q <= (frac_q == `CSC_FRAC_STEPS) ? 4'h0 : frac_q + 4'h1;
  end
  assign dif.codec_frac_tick = dif.ref_en && (frac_q == 4'h0 || frac_q == 4'h6); // see (R2)
endmodule

/* File: csc_pkg.sv */
// types shared by the clock synthesis control files
package csc_pkg;
  typedef enum logic [1:0] {CSC_SRC_EXT, CSC_SRC_GAP, CSC_SRC_PLL} csc_sw_state_t;
  typedef enum logic [1:0] {CSC_CO_PHASE, CSC_CO_RSV, CSC_CO_EXT, CSC_CO_EXT_HALF} csc_co_sel_t;
endpackage

/* File: csc_regs.svh */
// register offsets, field positions and timing counts of the clock synthesis control block
`ifndef CSC_REGS_SVH
`define CSC_REGS_SVH
`define CSC_CTRL_OFFSET   12'h000
`define CSC_EXT_OFFSET    12'h004
`define CSC_CTRL_RESET    16'h0000
`define CSC_ED_LSB        0
`define CSC_ED_MSB        3
`define CSC_YD_LSB        4
`define CSC_YD_MSB        7
`define CSC_RSV_LSB       8
`define CSC_RSV_MSB       9
`define CSC_CS_LSB        10
`define CSC_CS_MSB        11
`define CSC_GSM_BIT       12
`define CSC_PD_BIT        13
`define CSC_EN_BIT        14
`define CSC_LOCK_BIT      15
`define CSC_CLKOUT_DIS_BIT 0
`define CSC_LOCK_US       10
`define CSC_CLK_MHZ       25
`define CSC_FRAC_STEPS    4'hC
`endif
